// ==== hdl/ata_read_device.sv ====
// device end: decodes read commands and forms completion registers
`timescale 1ns/1ps
`default_nettype none
module ata_read_device #(
  parameter int BUF_BYTES = ata_read_pkg::BUFFER_BYTES,
  parameter bit BUFFER_SUPPORTED = 1'b1,
  parameter bit QUEUE_SUPPORTED = 1'b1,
  parameter bit REMOVABLE = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // task-file link
  ata_taskfile_if.device tf,
  // media engine: command issued
  output logic cmd_start,
  output logic [1:0] cmd_kind,
  output logic [27:0] start_lba,
  output logic lba_mode,
  output logic [8:0] sector_total,
  output logic [4:0] cmd_tag,
  // media engine: completion and error causes
  input wire logic done,
  input wire logic fail,
  input wire logic [27:0] fail_addr,
  input wire logic crc_err,
  input wire logic udma_err,
  input wire logic uncorrectable,
  input wire logic not_found,
  input wire logic geometry_bad,
  input wire logic out_of_range,
  input wire logic dev_fault,
  // removable media events
  input wire logic media_changed_ev,
  input wire logic change_request_ev,
  input wire logic no_media,
  // buffer fill from the write-buffer path
  input wire logic buf_wr,
  input wire logic [7:0] buf_wdata
);
  localparam int AW = $clog2(BUF_BYTES);
  initial begin
    if (BUF_BYTES != ata_read_pkg::BUFFER_BYTES) $error("buffer must be one sector");
  end
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_PIO = 2'b01,
    S_DMA = 2'b10
  } phase_t;
  typedef struct packed {
    phase_t phase;
    logic [7:0] features;
    logic [7:0] count;
    logic [7:0] sec;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] devhead;
    logic [7:0] error;
    logic [7:0] status;
    logic [7:0] rdata;
    logic media_changed;
    logic change_req;
    logic [AW-1:0] ptr;
    logic pio_valid;
    logic pio_phase;
    logic cmd_start;
    logic [1:0] cmd_kind;
    logic [27:0] start_lba;
    logic lba_mode;
    logic [8:0] sector_total;
    logic [4:0] cmd_tag;
  } dev_state_t;
  dev_state_t q;
  dev_state_t next_q;
  logic [7:0] buf_rdata;
  logic [AW-1:0] buf_addr;
  // one shared pointer keeps write and read buffer on the same bytes
  assign buf_addr = q.ptr;
  ata_sector_buffer #(.DEPTH(BUF_BYTES)) sector_buf (
    .clk(clk),
    .addr(buf_addr),
    .we(buf_wr && q.phase == S_IDLE),
    .wdata(buf_wdata),
    .rdata(buf_rdata)
  );
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] err;
    logic [7:0] op;
    err = ata_read_pkg::BYTE_ZERO;
    op = tf.wdata;
    next_q = q;
    next_q.cmd_start = 1'b0;
    next_q.pio_valid = 1'b0;
    if (media_changed_ev) next_q.media_changed = 1'b1;
    if (change_request_ev) next_q.change_req = 1'b1;
    if (buf_wr && q.phase == S_IDLE) next_q.ptr = AW'(q.ptr + 1'b1);
    next_q.rdata = ata_read_pkg::BYTE_ZERO;
    if (tf.rd) begin
      unique case (tf.addr)
        ata_read_pkg::REG_ERROR_FEATURES: next_q.rdata = q.error;
        ata_read_pkg::REG_SECTOR_COUNT: next_q.rdata = q.count;
        ata_read_pkg::REG_SECTOR_NUMBER: next_q.rdata = q.sec;
        ata_read_pkg::REG_CYL_LOW: next_q.rdata = q.cyl_lo;
        ata_read_pkg::REG_CYL_HIGH: next_q.rdata = q.cyl_hi;
        ata_read_pkg::REG_DEVICE_HEAD: next_q.rdata = q.devhead;
        ata_read_pkg::REG_STATUS_COMMAND: next_q.rdata = q.status;
        default: next_q.rdata = ata_read_pkg::BYTE_ZERO;
      endcase
    end
    unique case (q.phase)
      S_IDLE: begin
        if (tf.wr) begin
          unique case (tf.addr)
            ata_read_pkg::REG_ERROR_FEATURES: next_q.features = tf.wdata;
            ata_read_pkg::REG_SECTOR_COUNT: next_q.count = tf.wdata;
            ata_read_pkg::REG_SECTOR_NUMBER: next_q.sec = tf.wdata;
            ata_read_pkg::REG_CYL_LOW: next_q.cyl_lo = tf.wdata;
            ata_read_pkg::REG_CYL_HIGH: next_q.cyl_hi = tf.wdata;
            ata_read_pkg::REG_DEVICE_HEAD: next_q.devhead = tf.wdata;
            ata_read_pkg::REG_STATUS_COMMAND: begin
              next_q.status = ata_read_pkg::STATUS_RESET;
              next_q.error = ata_read_pkg::BYTE_ZERO;
              if (op == ata_read_pkg::OP_WRITE_BUFFER) begin
                next_q.ptr = '0;
              end else if (op == ata_read_pkg::OP_READ_BUFFER && BUFFER_SUPPORTED) begin
                next_q.ptr = '0;
                next_q.phase = S_PIO;
                next_q.pio_phase = 1'b0;
                next_q.status[ata_read_pkg::ST_BSY] = 1'b1;
              end else if (op == ata_read_pkg::OP_READ_DMA || op == ata_read_pkg::OP_READ_DMA_ALT
                           || (op == ata_read_pkg::OP_READ_DMA_QUEUED && QUEUE_SUPPORTED)) begin
                next_q.phase = S_DMA;
                next_q.status[ata_read_pkg::ST_BSY] = 1'b1;
                next_q.cmd_start = 1'b1;
                next_q.lba_mode = q.devhead[ata_read_pkg::DH_LBA];
                next_q.start_lba = {q.devhead[3:0], q.cyl_hi, q.cyl_lo, q.sec};
                if (op == ata_read_pkg::OP_READ_DMA_QUEUED) begin
                  next_q.cmd_kind = ata_read_pkg::CMD_QUEUED;
                  next_q.cmd_tag = q.count[7:ata_read_pkg::TAG_LSB];
                  next_q.sector_total = (q.features == ata_read_pkg::BYTE_ZERO) ?
                    ata_read_pkg::SECTORS_WHEN_ZERO : {1'b0, q.features};
                end else begin
                  next_q.cmd_kind = ata_read_pkg::CMD_DMA;
                  next_q.cmd_tag = '0;
                  next_q.sector_total = (q.count == ata_read_pkg::BYTE_ZERO) ?
                    ata_read_pkg::SECTORS_WHEN_ZERO : {1'b0, q.count};
                end
              end else begin
                next_q.error[ata_read_pkg::ERR_ABRT] = 1'b1;
                next_q.status[ata_read_pkg::ST_ERR] = 1'b1;
                next_q.status[ata_read_pkg::ST_DF] = dev_fault;
              end
            end
            default: next_q.features = q.features;
          endcase
        end
      end
      S_PIO: begin
        next_q.status[ata_read_pkg::ST_DRQ] = 1'b1;
        // buffer read has one cycle latency; pio_phase waits for it
        if (!q.pio_phase) begin
          next_q.pio_phase = 1'b1;
        end else if (!q.pio_valid || tf.pio_take) begin
          if (q.pio_valid && q.ptr == AW'(BUF_BYTES - 1)) begin
            next_q.phase = S_IDLE;
            next_q.status = ata_read_pkg::STATUS_RESET;
          end else begin
            if (q.pio_valid) next_q.ptr = AW'(q.ptr + 1'b1);
            next_q.pio_valid = !q.pio_valid;
            next_q.pio_phase = q.pio_valid ? 1'b0 : 1'b1;
          end
        end else begin
          next_q.pio_valid = 1'b1;
        end
      end
      S_DMA: begin
        if (done || fail) begin
          next_q.phase = S_IDLE;
          next_q.status = ata_read_pkg::STATUS_RESET;
          if (fail) begin
            err[ata_read_pkg::ERR_ICRC] = crc_err;
            err[ata_read_pkg::ERR_UNC] = uncorrectable;
            err[ata_read_pkg::ERR_MC] = REMOVABLE && (q.media_changed || media_changed_ev);
            err[ata_read_pkg::ERR_IDNF] = not_found || geometry_bad || out_of_range;
            err[ata_read_pkg::ERR_MCR] = REMOVABLE && (q.change_req || change_request_ev);
            err[ata_read_pkg::ERR_ABRT] = crc_err || udma_err;
            err[ata_read_pkg::ERR_NM] = REMOVABLE && no_media;
            next_q.error = err;
            next_q.status[ata_read_pkg::ST_ERR] = |err;
            next_q.status[ata_read_pkg::ST_DF] = dev_fault;
            next_q.sec = fail_addr[7:0];
            next_q.cyl_lo = fail_addr[15:8];
            next_q.cyl_hi = fail_addr[23:16];
            next_q.devhead = {q.devhead[7:4], fail_addr[27:24]};
          end
          // a media access consumes both removable flags; an unreported event in the closing cycle survives
          next_q.media_changed = !fail && media_changed_ev;
          next_q.change_req = !fail && change_request_ev;
        end
      end
      default: next_q.phase = S_IDLE;
    endcase
  end
  // ----------------------------------------------------------------
  // register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.status <= ata_read_pkg::STATUS_RESET;
    end else begin
      q <= next_q;
    end
  end
  assign tf.rdata = q.rdata;
  assign tf.pio_data = buf_rdata;
  assign tf.pio_valid = q.pio_valid;
  assign cmd_start = q.cmd_start;
  assign cmd_kind = q.cmd_kind;
  assign start_lba = q.start_lba;
  assign lba_mode = q.lba_mode;
  assign sector_total = q.sector_total;
  assign cmd_tag = q.cmd_tag;
endmodule : ata_read_device
`default_nettype wire

// ==== hdl/ata_read_host.sv ====
// host end: software port to task-file link
`timescale 1ns/1ps
`default_nettype none
module ata_read_host (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // software port
  input wire logic [3:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  // task-file link
  ata_taskfile_if.host tf
);
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic rd_tf;
    logic [7:0] rdata;
    logic [7:0] pio_byte;
    logic pio_full;
    logic pio_take;
    logic wait_rd;
  } host_state_t;
  host_state_t q;
  host_state_t next_q;
  always_comb begin
    next_q = q;
    next_q.wr = 1'b0;
    next_q.rd = 1'b0;
    next_q.pio_take = 1'b0;
    next_q.wait_rd = q.rd;
    next_q.rdata = ata_read_pkg::BYTE_ZERO;
    if (q.wait_rd) next_q.rdata = tf.rdata;
    if (sw_wr && sw_addr < ata_read_pkg::HOST_ADDR_GO) begin
      // commands go out only as written; ready gating is software's job
      next_q.addr = sw_addr[2:0];
      next_q.wdata = sw_wdata;
      next_q.wr = 1'b1;
    end
    if (sw_rd) begin
      unique case (sw_addr)
        ata_read_pkg::HOST_ADDR_STATE: next_q.rdata = {7'h00, q.pio_full};
        ata_read_pkg::HOST_ADDR_DATA: begin
          next_q.rdata = q.pio_byte;
          next_q.pio_full = 1'b0;
        end
        default: begin
          if (sw_addr < ata_read_pkg::HOST_ADDR_GO) begin
            next_q.addr = sw_addr[2:0];
            next_q.rd = 1'b1;
          end
        end
      endcase
    end
    // capture after the data read so an arriving byte wins over the clear
    if (tf.pio_valid && !q.pio_full && !q.pio_take) begin
      next_q.pio_byte = tf.pio_data;
      next_q.pio_full = 1'b1;
      next_q.pio_take = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
  assign tf.addr = q.addr;
  assign tf.wdata = q.wdata;
  assign tf.wr = q.wr;
  assign tf.rd = q.rd;
  assign tf.pio_take = q.pio_take;
  assign sw_rdata = q.rdata;
endmodule : ata_read_host
`default_nettype wire

// ==== hdl/ata_read_pkg.sv ====
// shared constants for the read command interpreter and its host end
package ata_read_pkg;
  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ_BUFFER = 8'hE4;
  localparam logic [7:0] OP_WRITE_BUFFER = 8'hE8;
  localparam logic [7:0] OP_READ_DMA = 8'hC8;
  localparam logic [7:0] OP_READ_DMA_ALT = 8'hC9;
  localparam logic [7:0] OP_READ_DMA_QUEUED = 8'hC7;
  // ----------------------------------------------------------------
  // task-file register indices
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_ERROR_FEATURES = 3'h1;
  localparam logic [2:0] REG_SECTOR_COUNT = 3'h2;
  localparam logic [2:0] REG_SECTOR_NUMBER = 3'h3;
  localparam logic [2:0] REG_CYL_LOW = 3'h4;
  localparam logic [2:0] REG_CYL_HIGH = 3'h5;
  localparam logic [2:0] REG_DEVICE_HEAD = 3'h6;
  localparam logic [2:0] REG_STATUS_COMMAND = 3'h7;
  // ----------------------------------------------------------------
  // bit positions
  // ----------------------------------------------------------------
  localparam int ERR_ICRC = 7;
  localparam int ERR_UNC = 6;
  localparam int ERR_MC = 5;
  localparam int ERR_IDNF = 4;
  localparam int ERR_MCR = 3;
  localparam int ERR_ABRT = 2;
  localparam int ERR_NM = 1;
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DF = 5;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int DH_LBA = 6;
  localparam int DH_DEV = 4;
  localparam int TAG_LSB = 3;
  localparam logic [7:0] STATUS_RESET = 8'h40;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [8:0] SECTORS_WHEN_ZERO = 9'h100;
  localparam int BUFFER_BYTES = 512;
  // ----------------------------------------------------------------
  // host-side software port map
  // ----------------------------------------------------------------
  localparam logic [3:0] HOST_ADDR_TF_BASE = 4'h0;
  localparam logic [3:0] HOST_ADDR_GO = 4'h8;
  localparam logic [3:0] HOST_ADDR_STATE = 4'h9;
  localparam logic [3:0] HOST_ADDR_DATA = 4'hA;
  typedef enum logic [1:0] {
    CMD_NONE = 2'b00,
    CMD_BUFFER = 2'b01,
    CMD_DMA = 2'b10,
    CMD_QUEUED = 2'b11
  } cmd_kind_t;
endpackage : ata_read_pkg

// ==== hdl/ata_sector_buffer.sv ====
// single-port sector buffer with byte-wide access
`timescale 1ns/1ps
`default_nettype none
module ata_sector_buffer #(
  parameter int DEPTH = ata_read_pkg::BUFFER_BYTES
) (
  // clock
  input wire logic clk,
  // access
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];
  initial begin
    if (DEPTH < 2) $error("depth too small");
  end
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : ata_sector_buffer
`default_nettype wire

// ==== hdl/ata_taskfile_if.sv ====
// task-file link between host end and device end
`timescale 1ns/1ps
`default_nettype none
interface ata_taskfile_if;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [7:0] pio_data;
  logic pio_valid;
  logic pio_take;
  modport device (input addr, input wdata, input wr, input rd, output rdata,
                  output pio_data, output pio_valid, input pio_take);
  modport host (output addr, output wdata, output wr, output rd, input rdata,
                input pio_data, input pio_valid, output pio_take);
endinterface : ata_taskfile_if
`default_nettype wire

// ==== verif/ata_read_link_assertions.sv ====
// concurrent checks on the task-file link between host end and device end
`timescale 1ns/1ps
`default_nettype none
module ata_read_link_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // task-file link
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [7:0] pio_data,
  input wire logic pio_valid,
  input wire logic pio_take
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic [7:0] last_cmd;
  logic dev_sel;
  logic st_rd;
  logic dh_rd;
  logic err_rd;
  logic err_any;
  logic [9:0] takes;
  always_ff @(posedge clk) begin
    if (srst) begin
      last_cmd <= 8'h00;
      dev_sel <= 1'b0;
      st_rd <= 1'b0;
      dh_rd <= 1'b0;
      err_rd <= 1'b0;
      err_any <= 1'b0;
      takes <= 10'h000;
    end else begin
      st_rd <= rd && addr == ata_read_pkg::REG_STATUS_COMMAND;
      dh_rd <= rd && addr == ata_read_pkg::REG_DEVICE_HEAD;
      err_rd <= rd && addr == ata_read_pkg::REG_ERROR_FEATURES;
      if (wr && addr == ata_read_pkg::REG_DEVICE_HEAD) begin
        dev_sel <= wdata[ata_read_pkg::DH_DEV];
      end
      // a new command starts a fresh error and byte count
      if (wr && addr == ata_read_pkg::REG_STATUS_COMMAND) begin
        last_cmd <= wdata;
        err_any <= 1'b0;
        takes <= 10'h000;
      end else begin
        if (err_rd && rdata != 8'h00) begin
          err_any <= 1'b1;
        end
        if (pio_take) begin
          takes <= takes + 10'h001;
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_err_flag_set: assert property (st_rd && err_any |-> rdata[ata_read_pkg::ST_ERR])
    else $error("error bits set but status error flag clear");
  a_err_status_clean: assert property (st_rd && rdata[ata_read_pkg::ST_ERR] |->
    !rdata[ata_read_pkg::ST_BSY] && rdata[ata_read_pkg::ST_DRDY] && !rdata[ata_read_pkg::ST_DRQ])
    else $error("error status has wrong busy, ready or request flags");
  a_idle_ready: assert property (st_rd && !rdata[ata_read_pkg::ST_BSY] && !rdata[ata_read_pkg::ST_ERR]
    |-> rdata[ata_read_pkg::ST_DRDY]) else $error("idle status without ready flag");
  a_pio_after_rdbuf: assert property ($rose(pio_valid) |-> last_cmd == ata_read_pkg::OP_READ_BUFFER)
    else $error("buffer byte offered without read buffer command");
  a_pio_held: assert property (pio_valid && !pio_take |=> pio_valid && $stable(pio_data))
    else $error("offered buffer byte changed before it was taken");
  a_pio_bytes: assert property (takes >= 10'h200 |-> !pio_valid && takes == 10'h200)
    else $error("more than one buffer of bytes offered");
  a_dma_busy: assert property (wr && addr == ata_read_pkg::REG_STATUS_COMMAND &&
    (wdata == ata_read_pkg::OP_READ_DMA || wdata == ata_read_pkg::OP_READ_DMA_ALT)
    ##[2:7] st_rd |-> rdata[ata_read_pkg::ST_BSY]) else $error("dma read opcode not taken");
  a_dev_bit_kept: assert property (dh_rd |-> rdata[ata_read_pkg::DH_DEV] == dev_sel)
    else $error("device select bit lost");
endmodule : ata_read_link_assertions
`default_nettype wire

// ==== verif/tb_ata_read_command_register_outputs.sv ====
// testbench: host end and device end joined, driven from software port and media side
`timescale 1ns/1ps
`default_nettype none
module tb_ata_read_command_register_outputs;
  localparam logic [27:0] FAIL_AT = 28'hB8765F3;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] sw_addr = 4'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [7:0] sw_rdata;
  logic done = 1'b0;
  logic fail = 1'b0;
  logic [7:0] cause = 8'h00;
  logic mc_ev = 1'b0;
  logic mcr_ev = 1'b0;
  logic buf_wr = 1'b0;
  logic [7:0] buf_wdata = 8'h00;
  logic cmd_start;
  logic [1:0] cmd_kind;
  logic [27:0] start_lba;
  logic lba_mode;
  logic [8:0] sector_total;
  logic [4:0] cmd_tag;
  logic [39:0] seen = 40'h0;
  logic [4:0] tag_seen = 5'h00;
  logic [7:0] d;
  logic [7:0] causes [8] = '{8'hC0, 8'h22, 8'h10, 8'h08, 8'h01, 8'h20, 8'h20, 8'h04};
  logic [7:0] errs [8] = '{8'h84, 8'h40, 8'h10, 8'h10, 8'h02, 8'h68, 8'h40, 8'h10};
  int starts = 0;
  int err_total = 0;
  int compares = 0;
  always #12.5 clk = ~clk;
  ata_taskfile_if link();
  ata_read_device ata_read_device_inst (.clk(clk), .srst(srst), .tf(link), .cmd_start(cmd_start),
    .cmd_kind(cmd_kind), .start_lba(start_lba), .lba_mode(lba_mode), .sector_total(sector_total),
    .cmd_tag(cmd_tag), .done(done), .fail(fail), .fail_addr(FAIL_AT), .crc_err(cause[7]),
    .udma_err(cause[6]), .uncorrectable(cause[5]), .not_found(cause[4]), .geometry_bad(cause[3]),
    .out_of_range(cause[2]), .dev_fault(cause[1]), .media_changed_ev(mc_ev),
    .change_request_ev(mcr_ev), .no_media(cause[0]), .buf_wr(buf_wr), .buf_wdata(buf_wdata));
  ata_read_host ata_read_host_inst (.clk(clk), .srst(srst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .tf(link));
  ata_read_link_assertions ata_read_link_assertions_inst (.clk(clk), .srst(srst), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .pio_data(link.pio_data),
    .pio_valid(link.pio_valid), .pio_take(link.pio_take));
  // issue pulse lasts one cycle, so catch its fields here
  always @(posedge clk) begin
    if (cmd_start === 1'b1) begin
      seen <= {cmd_kind, lba_mode, sector_total, start_lba};
      tag_seen <= cmd_tag;
      starts <= starts + 1;
    end
  end
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic check(input string n, input logic [39:0] g, input logic [39:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic sw_write(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask : sw_write
  task automatic sw_read(input logic [3:0] a, input int lat, output logic [7:0] v);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    repeat (lat - 1) @(posedge clk);
    #1 v = sw_rdata;
  endtask : sw_read
  task automatic tf_check(input logic [2:0] r, input logic [7:0] e);
    logic [7:0] v;
    sw_read(ata_read_pkg::HOST_ADDR_TF_BASE + {1'b0, r}, 3, v);
    check($sformatf("task file reg %0d", r), {32'h0, v}, {32'h0, e});
  endtask : tf_check
  task automatic run_cmd(input logic [7:0] op, fe, cnt, dh);
    logic [7:0] v [7];
    int n;
    v = '{fe, cnt, 8'h21, 8'h43, 8'h65, dh, op};
    n = starts;
    for (int r = 0; r < 7; r++) sw_write(ata_read_pkg::HOST_ADDR_TF_BASE + 4'(r + 1), v[r]);
    sw_read(ata_read_pkg::HOST_ADDR_TF_BASE + 4'h7, 3, d);
    for (int i = 0; i < 40 && starts == n; i++) @(posedge clk);
  endtask : run_cmd
  task automatic finish_cmd(input logic bad, input logic [7:0] c);
    @(posedge clk);
    cause <= c;
    fail <= bad;
    done <= !bad;
    @(posedge clk);
    fail <= 1'b0;
    done <= 1'b0;
    cause <= 8'h00;
    repeat (3) @(posedge clk);
  endtask : finish_cmd
  task automatic close_out();
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    tf_check(3'h7, ata_read_pkg::STATUS_RESET);
    for (int i = 0; i < 2; i++) begin
      run_cmd(i ? ata_read_pkg::OP_READ_DMA_ALT : ata_read_pkg::OP_READ_DMA, 8'h00, 8'(i), i ? 8'h03 : 8'h5A);
      check("dma issue", seen, {ata_read_pkg::CMD_DMA, i ? 1'b0 : 1'b1, i ? 9'h001 : 9'h100,
        i ? 4'h3 : 4'hA, 24'h654321});
      finish_cmd(1'b0, 8'h00);
      tf_check(3'h7, ata_read_pkg::STATUS_RESET);
      tf_check(3'h6, i ? 8'h03 : 8'h5A);
    end
    run_cmd(ata_read_pkg::OP_READ_DMA_QUEUED, 8'h05, 8'hA8, 8'h5A);
    check("queued issue", {seen[39:28], tag_seen}, {ata_read_pkg::CMD_QUEUED, 1'b1, 9'h005, 5'h15});
    finish_cmd(1'b0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      if (i == 5) begin
        @(posedge clk);
        mc_ev <= 1'b1;
        mcr_ev <= 1'b1;
        @(posedge clk);
        mc_ev <= 1'b0;
        mcr_ev <= 1'b0;
      end
      run_cmd(ata_read_pkg::OP_READ_DMA, 8'h00, 8'h10, 8'h5A);
      finish_cmd(1'b1, causes[i]);
      tf_check(3'h1, errs[i]);
      tf_check(3'h7, causes[i][1] ? 8'h61 : 8'h41);
      for (int r = 3; r < 7; r++) tf_check(3'(r), r == 6 ? {4'h5, FAIL_AT[27:24]} : FAIL_AT[8*(r-3) +: 8]);
    end
    run_cmd(8'hA5, 8'h00, 8'h00, 8'h5A);
    tf_check(3'h1, 8'h04);
    tf_check(3'h7, 8'h41);
    // buffer round trip: fill from the write side, read back over the link
    run_cmd(ata_read_pkg::OP_WRITE_BUFFER, 8'h00, 8'h00, 8'h5A);
    for (int i = 0; i < ata_read_pkg::BUFFER_BYTES; i++) begin
      @(posedge clk);
      buf_wr <= 1'b1;
      buf_wdata <= 8'(i) ^ 8'h5A;
    end
    @(posedge clk);
    buf_wr <= 1'b0;
    run_cmd(ata_read_pkg::OP_READ_BUFFER, 8'h00, 8'h00, 8'h5A);
    for (int i = 0; i < ata_read_pkg::BUFFER_BYTES; i++) begin
      d = 8'h00;
      for (int k = 0; k < 20 && d[0] !== 1'b1; k++) sw_read(ata_read_pkg::HOST_ADDR_STATE, 1, d);
      sw_read(ata_read_pkg::HOST_ADDR_DATA, 1, d);
      check("buffer byte", {32'h0, d}, {32'h0, 8'(i) ^ 8'h5A});
    end
    repeat (10) @(posedge clk);
    tf_check(3'h7, ata_read_pkg::STATUS_RESET);
    close_out();
  end
  initial begin
    #(25 * 40000);
    err_total++;
    close_out();
  end
endmodule : tb_ata_read_command_register_outputs
`default_nettype wire
